// ==== verilog/bcm_map.svh ====
// Offsets, field positions, write masks and reset values of the break match block
// Assumes a 32-bit AXI4-Lite slave with an 8-bit word-aligned address
`ifndef BCM_MAP_SVH
`define BCM_MAP_SVH
`define BCM_AW           8
`define BCM_OFS_QUAL_A   8'h00
`define BCM_OFS_ADDR_A   8'h04
`define BCM_OFS_ADDR_B   8'h08
`define BCM_OFS_MASK_B   8'h0c
`define BCM_OFS_QUAL_B   8'h10
`define BCM_OFS_STATUS   8'h14
`define BCM_OFS_IRQ_EN   8'h18
`define BCM_QA_WMASK     16'h00ff
`define BCM_QB_WMASK     16'h0300
`define BCM_RST_QUAL     16'h0000
`define BCM_RST_WORD     32'h00000000
`define BCM_RST_EV       2'h0
`define BCM_QB_MEM_EN    9
`define BCM_QB_MEM_SEL   8
`define BCM_QA_MST_HI    7
`define BCM_QA_MST_LO    6
`define BCM_QA_ACC_HI    5
`define BCM_QA_ACC_LO    4
`define BCM_QA_DIR_HI    3
`define BCM_QA_DIR_LO    2
`define BCM_QA_SIZE_HI   1
`define BCM_QA_SIZE_LO   0
`define BCM_EV_A         0
`define BCM_EV_B         1
`define BCM_RESP_OKAY    2'h0
`define BCM_RESP_SLVERR  2'h2
`endif

// ==== verilog/bcm_pkg.sv ====
// Types shared by the break match block
// Assumes the bus cycle arrives on the same clock as the block
package bcm_pkg;
  typedef struct packed {
    logic        valid;
    logic        dma;
    logic        fetch;
    logic        write;
    logic [1:0]  size;
    logic [31:0] la;
    logic [15:0] xa;
    logic [15:0] ya;
  } bcm_cycle_s;
  typedef enum logic [1:0] {W_COLLECT = 2'h1, W_RESP = 2'h2} bcm_wst_e;
  typedef enum logic [1:0] {R_IDLE = 2'h1, R_RESP = 2'h2} bcm_rst_e;
endpackage : bcm_pkg

// ==== verilog/bcm_top.sv ====
// Break condition match: channel A cycle qualifier and address, channel B masked address
// Assumes bus cycles come from logic on CLOCK and software uses AXI4-Lite
//
// Summary of operation
// - Qualifier A upper byte reads zero
// - Master field: 00 off, x1 CPU, 10 DMA
// - Access field: off, fetch, data, either
// - Direction field: off, read, write, either
// - Size field: off, byte, word, longword
// - Reset clears qualifier A
// - Memory bus off: full address compare
// - Memory bus on: halves versus X/Y bits 15..1
// - Only the selected X or Y bus used
// - Reset clears channel B address
// - Set mask bit drops address bit
// - Mask halves follow the same bus mapping
// - Reset clears channel B mask
// - Channel A address compares logic bus
// - Bit 9 enables memory bus, bit 8 selects Y
// - Satisfied condition raises a break event
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "bcm_map.svh"
module bcm_top
  import bcm_pkg::*;
(
  input  wire logic               CLOCK,
  input  wire logic               RST,
  input  wire logic               CE,
  input  wire bcm_cycle_s         BUS_CYCLE,
  input  wire logic [`BCM_AW-1:0] AWADDR,
  input  wire logic               AWVALID,
  output logic                    AWREADY,
  input  wire logic [31:0]        WDATA,
  input  wire logic [3:0]         WSTRB,
  input  wire logic               WVALID,
  output logic                    WREADY,
  output logic [1:0]              BRESP,
  output logic                    BVALID,
  input  wire logic               BREADY,
  input  wire logic [`BCM_AW-1:0] ARADDR,
  input  wire logic               ARVALID,
  output logic                    ARREADY,
  output logic [31:0]             RDATA,
  output logic [1:0]              RRESP,
  output logic                    RVALID,
  input  wire logic               RREADY,
  output logic                    BREAK_A,
  output logic                    BREAK_B,
  output logic                    IRQ
);

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : apply_strb

  // One where every unmasked bit agrees
  function automatic logic masked_eq(input logic [31:0] ref_v, input logic [31:0] msk,
                                     input logic [31:0] val);
    return ((ref_v ^ val) & ~msk) == 32'h00000000;
  endfunction : masked_eq

  // 00 always matches, 01 first kind, 10 second kind, 11 either
  function automatic logic fld_ok(input logic [1:0] f, input logic k1, input logic k2);
    return (f == 2'h0) || (f[0] && k1) || (f[1] && k2);
  endfunction : fld_ok

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] qual_a_q, qual_a_d, qual_b_q, qual_b_d;
  logic [31:0] addr_a_q, addr_a_d, addr_b_q, addr_b_d, mask_b_q, mask_b_d;
  logic [1:0]  status_q, status_d, irq_en_q, irq_en_d;
  logic        irq_q, irq_d;

  bcm_wst_e          wst_q, wst_d;
  logic              aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [`BCM_AW-1:0] waddr_q, waddr_d;
  logic [31:0]       wdata_q, wdata_d;
  logic [3:0]        wstrb_q, wstrb_d;
  logic              awready_q, awready_d, wready_q, wready_d;
  logic [1:0]        bresp_q, bresp_d;
  logic              do_wr;

  bcm_rst_e          rst_q, rst_d;
  logic              arready_q, arready_d;
  logic [31:0]       rdata_q, rdata_d;
  logic [1:0]        rresp_q, rresp_d;
  logic [`BCM_AW-1:0] raddr_q, raddr_d;

  logic              hit_a, hit_b, mst_ok;
  logic              brk_a_q, brk_a_d, brk_b_q, brk_b_d;
  logic [31:0]       b_ref, b_msk, b_val;
  logic [31:0]       qa_new, qb_new;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order, response after both
  always_comb begin
    wst_d     = wst_q;
    aw_hold_d = aw_hold_q;
    w_hold_d  = w_hold_q;
    waddr_d   = waddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bresp_d   = bresp_q;
    do_wr     = 1'b0;
    case (wst_q)
      W_COLLECT: begin
        if (AWVALID && awready_q) begin
          aw_hold_d = 1'b1;
          waddr_d   = AWADDR;
        end
        if (WVALID && wready_q) begin
          w_hold_d = 1'b1;
          wdata_d  = WDATA;
          wstrb_d  = WSTRB;
        end
        if (aw_hold_q && w_hold_q) begin
          do_wr     = 1'b1;
          aw_hold_d = 1'b0;
          w_hold_d  = 1'b0;
          wst_d     = W_RESP;
          if (waddr_q == `BCM_OFS_QUAL_A || waddr_q == `BCM_OFS_ADDR_A || waddr_q == `BCM_OFS_ADDR_B ||
              waddr_q == `BCM_OFS_MASK_B || waddr_q == `BCM_OFS_QUAL_B || waddr_q == `BCM_OFS_STATUS ||
              waddr_q == `BCM_OFS_IRQ_EN) begin
            bresp_d = `BCM_RESP_OKAY;
          end else begin
            bresp_d = `BCM_RESP_SLVERR;
          end
        end
      end
      W_RESP: begin
        if (BREADY) begin
          wst_d = W_COLLECT;
        end
      end
      default: wst_d = W_COLLECT;
    endcase
    awready_d = (wst_d == W_COLLECT) && !aw_hold_d;
    wready_d  = (wst_d == W_COLLECT) && !w_hold_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one cycle from address taken to data valid
  always_comb begin
    rst_d   = rst_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    raddr_d = raddr_q;
    case (rst_q)
      R_IDLE: begin
        if (ARVALID && arready_q) begin
          rst_d   = R_RESP;
          raddr_d = ARADDR;
          rresp_d = `BCM_RESP_OKAY;
          if (ARADDR == `BCM_OFS_QUAL_A) begin
            rdata_d = {16'h0000, qual_a_q};
          end else if (ARADDR == `BCM_OFS_ADDR_A) begin
            rdata_d = addr_a_q;
          end else if (ARADDR == `BCM_OFS_ADDR_B) begin
            rdata_d = addr_b_q;
          end else if (ARADDR == `BCM_OFS_MASK_B) begin
            rdata_d = mask_b_q;
          end else if (ARADDR == `BCM_OFS_QUAL_B) begin
            rdata_d = {16'h0000, qual_b_q};
          end else if (ARADDR == `BCM_OFS_STATUS) begin
            rdata_d = {30'h0, status_q};
          end else if (ARADDR == `BCM_OFS_IRQ_EN) begin
            rdata_d = {30'h0, irq_en_q};
          end else begin
            rdata_d = 32'h00000000;
            rresp_d = `BCM_RESP_SLVERR;
          end
        end
      end
      R_RESP: begin
        if (RREADY) begin
          rst_d = R_IDLE;
        end
      end
      default: rst_d = R_IDLE;
    endcase
    arready_d = (rst_d == R_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Match logic
  always_comb begin
    // Master field: bit 6 alone picks CPU, so 11 means CPU too
    if (qual_a_q[`BCM_QA_MST_HI:`BCM_QA_MST_LO] == 2'h0) begin
      mst_ok = 1'b1;
    end else if (qual_a_q[`BCM_QA_MST_LO]) begin
      mst_ok = !BUS_CYCLE.dma;
    end else begin
      mst_ok = BUS_CYCLE.dma;
    end
    hit_a = BUS_CYCLE.valid && mst_ok &&
            fld_ok(qual_a_q[`BCM_QA_ACC_HI:`BCM_QA_ACC_LO], BUS_CYCLE.fetch, !BUS_CYCLE.fetch) &&
            fld_ok(qual_a_q[`BCM_QA_DIR_HI:`BCM_QA_DIR_LO], !BUS_CYCLE.write, BUS_CYCLE.write) &&
            (qual_a_q[`BCM_QA_SIZE_HI:`BCM_QA_SIZE_LO] == 2'h0 ||
             qual_a_q[`BCM_QA_SIZE_HI:`BCM_QA_SIZE_LO] == BUS_CYCLE.size) &&
            masked_eq(addr_a_q, `BCM_RST_WORD, BUS_CYCLE.la);
    // Bit 0 of the X/Y compare never takes part; only one X/Y half is live
    if (!qual_b_q[`BCM_QB_MEM_EN]) begin
      b_ref = addr_b_q;
      b_msk = mask_b_q;
      b_val = BUS_CYCLE.la;
    end else if (!qual_b_q[`BCM_QB_MEM_SEL]) begin
      b_ref = {16'h0000, addr_b_q[31:17], 1'b0};
      b_msk = {16'hffff, mask_b_q[31:17], 1'b1};
      b_val = {16'h0000, BUS_CYCLE.xa[15:1], 1'b0};
    end else begin
      b_ref = {16'h0000, addr_b_q[15:1], 1'b0};
      b_msk = {16'hffff, mask_b_q[15:1], 1'b1};
      b_val = {16'h0000, BUS_CYCLE.ya[15:1], 1'b0};
    end
    hit_b   = BUS_CYCLE.valid && masked_eq(b_ref, b_msk, b_val);
    brk_a_d = hit_a;
    brk_b_d = hit_b;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  always_comb begin
    qual_a_d = qual_a_q;
    qual_b_d = qual_b_q;
    addr_a_d = addr_a_q;
    addr_b_d = addr_b_q;
    mask_b_d = mask_b_q;
    irq_en_d = irq_en_q;
    status_d = status_q;
    qa_new   = apply_strb({16'h0000, qual_a_q}, wdata_q, wstrb_q);
    qb_new   = apply_strb({16'h0000, qual_b_q}, wdata_q, wstrb_q);
    if (do_wr) begin
      if (waddr_q == `BCM_OFS_QUAL_A) begin
        qual_a_d = qa_new[15:0] & `BCM_QA_WMASK;
      end else if (waddr_q == `BCM_OFS_ADDR_A) begin
        addr_a_d = apply_strb(addr_a_q, wdata_q, wstrb_q);
      end else if (waddr_q == `BCM_OFS_ADDR_B) begin
        addr_b_d = apply_strb(addr_b_q, wdata_q, wstrb_q);
      end else if (waddr_q == `BCM_OFS_MASK_B) begin
        mask_b_d = apply_strb(mask_b_q, wdata_q, wstrb_q);
      end else if (waddr_q == `BCM_OFS_QUAL_B) begin
        qual_b_d = qb_new[15:0] & `BCM_QB_WMASK;
      end else if (waddr_q == `BCM_OFS_STATUS && wstrb_q[0]) begin
        status_d = status_q & ~wdata_q[1:0];
      end else if (waddr_q == `BCM_OFS_IRQ_EN && wstrb_q[0]) begin
        irq_en_d = wdata_q[1:0];
      end
    end
    // Set after clear, so an event in the clearing cycle survives
    status_d[`BCM_EV_A] = status_d[`BCM_EV_A] | brk_a_q;
    status_d[`BCM_EV_B] = status_d[`BCM_EV_B] | brk_b_q;
    irq_d = |(status_d & irq_en_d);
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      qual_a_q  <= `BCM_RST_QUAL;
      qual_b_q  <= `BCM_RST_QUAL;
      addr_a_q  <= `BCM_RST_WORD;
      addr_b_q  <= `BCM_RST_WORD;
      mask_b_q  <= `BCM_RST_WORD;
      status_q  <= `BCM_RST_EV;
      irq_en_q  <= `BCM_RST_EV;
      irq_q     <= 1'b0;
      brk_a_q   <= 1'b0;
      brk_b_q   <= 1'b0;
      wst_q     <= W_COLLECT;
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      waddr_q   <= '0;
      wdata_q   <= `BCM_RST_WORD;
      wstrb_q   <= 4'h0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bresp_q   <= `BCM_RESP_OKAY;
      rst_q     <= R_IDLE;
      arready_q <= 1'b0;
      rdata_q   <= `BCM_RST_WORD;
      rresp_q   <= `BCM_RESP_OKAY;
      raddr_q   <= '0;
    end else if (CE) begin
      qual_a_q  <= qual_a_d;
      qual_b_q  <= qual_b_d;
      addr_a_q  <= addr_a_d;
      addr_b_q  <= addr_b_d;
      mask_b_q  <= mask_b_d;
      status_q  <= status_d;
      irq_en_q  <= irq_en_d;
      irq_q     <= irq_d;
      brk_a_q   <= brk_a_d;
      brk_b_q   <= brk_b_d;
      wst_q     <= wst_d;
      aw_hold_q <= aw_hold_d;
      w_hold_q  <= w_hold_d;
      waddr_q   <= waddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bresp_q   <= bresp_d;
      rst_q     <= rst_d;
      arready_q <= arready_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      raddr_q   <= raddr_d;
    end
  end

  assign AWREADY = awready_q;
  assign WREADY  = wready_q;
  assign BVALID  = (wst_q == W_RESP);
  assign BRESP   = bresp_q;
  assign ARREADY = arready_q;
  assign RVALID  = (rst_q == R_RESP);
  assign RDATA   = rdata_q;
  assign RRESP   = rresp_q;
  assign BREAK_A = brk_a_q;
  assign BREAK_B = brk_b_q;
  assign IRQ     = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  chk_resv_zero: assert property (RVALID && raddr_q == `BCM_OFS_QUAL_A |-> RDATA[31:8] == 24'h000000)
    else $error("qualifier A upper bits not zero");
  chk_master_dma: assert property (CE && BUS_CYCLE.valid && qual_a_q[7:6] == 2'h2 && !BUS_CYCLE.dma |=> !BREAK_A)
    else $error("DMA-only break on CPU cycle");
  chk_access_type: assert property (CE && qual_a_q[5:4] == 2'h1 && !BUS_CYCLE.fetch |=> !BREAK_A)
    else $error("fetch-only break on data access");
  chk_direction: assert property (CE && qual_a_q[3:2] == 2'h2 && !BUS_CYCLE.write |=> !BREAK_A)
    else $error("write-only break on read");
  chk_size_sel: assert property (CE && qual_a_q[1:0] != 2'h0 && qual_a_q[1:0] != BUS_CYCLE.size |=> !BREAK_A)
    else $error("break on wrong operand size");
  chk_reset_clear: assert property (disable iff (1'b0) RST |=> qual_a_q == 16'h0000 && addr_b_q == 32'h0 && mask_b_q == 32'h0)
    else $error("reset did not clear registers");
  chk_full_addr: assert property (CE && BUS_CYCLE.valid && !qual_b_q[9] && ((addr_b_q ^ BUS_CYCLE.la) & ~mask_b_q) == 32'h0 |=> BREAK_B)
    else $error("missed full-address break on B");
  chk_x_half: assert property (CE && qual_b_q[9] && !qual_b_q[8] && ((addr_b_q[31:17] ^ BUS_CYCLE.xa[15:1]) & ~mask_b_q[31:17]) != 15'h0 |=> !BREAK_B)
    else $error("X-bus break on unmatched address");
  chk_event_irq: assert property (CE && BREAK_A && irq_en_q[0] ##1 CE |=> IRQ)
    else $error("break A did not raise interrupt");

  cov_break_a: cover property (BREAK_A && qual_a_q != 16'h0000);
  cov_break_y: cover property (BREAK_B && qual_b_q[9] && qual_b_q[8]);
  cov_irq_clear: cover property (IRQ ##[1:20] !IRQ);

endmodule : bcm_top

// ==== tb/bcm_bus_model.sv ====
// Behavioural source of processor and DMA bus cycles seen by the break match block
// Assumes the bench calls send right after a rising edge, once per cycle, then rest
`timescale 1ns/1ps
module bcm_bus_model
  import bcm_pkg::*;
(
  input  wire logic CLOCK,
  output bcm_cycle_s BUS_CYCLE
);
  initial BUS_CYCLE = '0;

  task automatic send(input bcm_cycle_s c);
    BUS_CYCLE <= c;
    @(posedge CLOCK);
  endtask : send

  // Idle payload is inverted so a stale address can never pass for a live one
  task automatic rest();
    bcm_cycle_s t;
    t = ~BUS_CYCLE;
    t.valid = 1'b0;
    BUS_CYCLE <= t;
  endtask : rest
endmodule : bcm_bus_model

// ==== tb/tb.sv ====
// Self-checking bench for the break match block: registers over AXI4-Lite, break pulses, interrupt
// Assumes bcm_top as declared, one 200 MHz clock and a bus cycle model on its far side
`timescale 1ns/1ps
`include "bcm_map.svh"
module tb;
  import bcm_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, r;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, brk_a, brk_b, irq, vq = 1'b0;
  logic [1:0] bresp, rresp, st = 2'h0;
  logic [31:0] seed = 32'hd8e3, qa = '0, aa = '0, ab = '0, mb = '0, qb = '0;
  bcm_cycle_s cyc;
  logic [33:0] exp_rd[$];
  logic [1:0] exp_wr[$];
  logic [1:0] exp_brk[$];
  int mismatches = 0;
  int n_compared = 0;
  int i;

  always #2.5 clock = ~clock;

  bcm_top u_dut (.CLOCK(clock), .RST(rst), .CE(ce), .BUS_CYCLE(cyc), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
    .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .BREAK_A(brk_a), .BREAK_B(brk_b), .IRQ(irq));
  bcm_bus_model u_bus (.CLOCK(clock), .BUS_CYCLE(cyc));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [33:0] got, input logic [33:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic conclude();
    $display("Counts: %0d compared, %0d mismatches", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task automatic hang();
    mismatches++;
    $display("Error t=%0t handshake wait ran out", $time);
    conclude();
  endtask : hang

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  ////////////////////////////////////////////////////////////////////////////////
  // Master waits on the answer itself; only the loop bound ends a stuck wait
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    int n;
    exp_wr.push_back(resp);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    @(posedge clock);
    if (n == 50) hang();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    exp_rd.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    @(posedge clock);
    if (n == 50) hang();
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic exp_a(input bcm_cycle_s c);
    logic ok;
    ok = c.valid && c.la == aa;
    ok = ok && (qa[7:6] == 2'h0 || (qa[6] ? !c.dma : c.dma));
    ok = ok && (qa[5:4] != 2'h1 || c.fetch) && (qa[5:4] != 2'h2 || !c.fetch);
    ok = ok && (qa[3:2] != 2'h1 || !c.write) && (qa[3:2] != 2'h2 || c.write);
    return ok && (qa[1:0] == 2'h0 || qa[1:0] == c.size);
  endfunction : exp_a

  function automatic logic exp_b(input bcm_cycle_s c);
    logic [31:0] d;
    d = qb[9] ? (qb[8] ? {16'h0, ab[15:1] ^ c.ya[15:1], 1'b0} : {ab[31:17] ^ c.xa[15:1], 17'h0}) : ab ^ c.la;
    return c.valid && (d & ~mb) == 32'h0;
  endfunction : exp_b

  // Sparse flips around the target address give both hits and near misses
  task automatic bus(input logic [31:0] near);
    bcm_cycle_s c;
    logic [31:0] f, q;
    q = rnd();
    f = q[7] ? 32'h0 : rnd() & rnd() & rnd() & rnd();
    c.valid = 1'b1;
    c.dma = q[0];
    c.fetch = q[1];
    c.write = q[2];
    c.size = (q[4:3] == 2'h0) ? 2'h3 : q[4:3];
    c.la = near ^ f;
    c.xa = near[31:16] ^ f[31:16];
    c.ya = near[15:0] ^ f[15:0];
    exp_brk.push_back({exp_a(c), exp_b(c)});
    st = st | {exp_b(c), exp_a(c)};
    u_bus.send(c);
  endtask : bus

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    vq <= cyc.valid;
    if (vq) check(34'({brk_a, brk_b}), 34'(exp_brk.pop_front()), "break pulse");
    else if (!rst) check(34'({brk_a, brk_b}), 34'h0, "idle break");
    if (rvalid && rready) check({rresp, rdata}, exp_rd.pop_front(), "read data");
    if (bvalid && bready) check(34'(bresp), 34'(exp_wr.pop_front()), "write response");
  end

  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    for (i = 0; i < 7; i++) rd(8'(4 * i), 34'h0);
    rd(8'h1c, {`BCM_RESP_SLVERR, 32'h0});
    wr(8'hfc, 32'hffffffff, `BCM_RESP_SLVERR);
    $display("Test reset_values done");
    for (i = 0; i < 40; i++) begin
      r = rnd();
      qa = {24'h0, r[7:0]};
      aa = rnd();
      wr(`BCM_OFS_QUAL_A, r, `BCM_RESP_OKAY);
      rd(`BCM_OFS_QUAL_A, {`BCM_RESP_OKAY, qa});
      wr(`BCM_OFS_ADDR_A, aa, `BCM_RESP_OKAY);
      repeat (4) bus(aa);
      u_bus.rest();
    end
    $display("Test channel_a done");
    for (i = 0; i < 40; i++) begin
      r = rnd();
      qb = {22'h0, r[9:8], 8'h0};
      ab = rnd();
      mb = rnd() & rnd() & rnd();
      wr(`BCM_OFS_QUAL_B, r, `BCM_RESP_OKAY);
      rd(`BCM_OFS_QUAL_B, {`BCM_RESP_OKAY, qb});
      wr(`BCM_OFS_ADDR_B, ab, `BCM_RESP_OKAY);
      wr(`BCM_OFS_MASK_B, mb, `BCM_RESP_OKAY);
      rd(`BCM_OFS_MASK_B, {`BCM_RESP_OKAY, mb});
      rd(`BCM_OFS_ADDR_B, {`BCM_RESP_OKAY, ab});
      repeat (4) bus(ab);
      u_bus.rest();
    end
    $display("Test channel_b done");
    rd(`BCM_OFS_STATUS, {`BCM_RESP_OKAY, 30'h0, st});
    check(34'(irq), 34'h0, "masked irq");
    wr(`BCM_OFS_IRQ_EN, 32'h3, `BCM_RESP_OKAY);
    repeat (2) @(posedge clock);
    check(34'(irq), 34'(st != 2'h0), "enabled irq");
    wr(`BCM_OFS_STATUS, 32'h3, `BCM_RESP_OKAY);
    st = 2'h0;
    repeat (2) @(posedge clock);
    check(34'(irq), 34'h0, "cleared irq");
    mb = 32'hffffffff;
    qb = 32'h0;
    wr(`BCM_OFS_QUAL_B, 32'h0, `BCM_RESP_OKAY);
    wr(`BCM_OFS_MASK_B, mb, `BCM_RESP_OKAY);
    bus(ab);
    u_bus.rest();
    repeat (3) @(posedge clock);
    check(34'(irq), 34'h1, "break irq");
    wr(`BCM_OFS_IRQ_EN, 32'h1, `BCM_RESP_OKAY);
    repeat (2) @(posedge clock);
    check(34'(irq), 34'(st[0]), "mask b irq");
    wr(`BCM_OFS_STATUS, {30'h0, st}, `BCM_RESP_OKAY);
    rd(`BCM_OFS_STATUS, {`BCM_RESP_OKAY, 32'h0});
    $display("Test interrupt done");
    conclude();
  end
endmodule : tb
